// *** thermo_twowire_pkg.sv ***
// Shared constants and types for the thermometer two-wire target.
package thermo_twowire_pkg;

  // Strap level codes as reported by the tri-state pad sense circuit.
  localparam logic [1:0] STRAP_LOW   = 2'h0;
  localparam logic [1:0] STRAP_HIGH  = 2'h1;
  localparam logic [1:0] STRAP_FLOAT = 2'h2;

  // Register-select codes.
  localparam logic [1:0] SEL_TEMP  = 2'h0;
  localparam logic [1:0] SEL_CFG   = 2'h1;
  localparam logic [1:0] SEL_THYST = 2'h2;
  localparam logic [1:0] SEL_TOS   = 2'h3;

  localparam logic [7:0] SOFT_POR_CODE  = 8'h54;
  localparam logic [5:0] SEL_UPPER_ZERO = 6'h00;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  // Values after reset.
  localparam logic [1:0]  SEL_RESET   = SEL_TEMP;
  localparam logic [7:0]  CFG_RESET   = 8'h00;
  localparam logic [15:0] THYST_RESET = 16'h0000;
  localparam logic [15:0] TOS_RESET   = 16'h0000;
  localparam logic [6:0]  ADDR_RESET  = 7'h00;

  typedef struct packed {
    logic [1:0] strap_2;
    logic [1:0] strap_1;
    logic [1:0] strap_0;
  } straps_t;

  typedef struct packed {
    logic [7:0]  cfg;
    logic [15:0] thyst;
    logic [15:0] tos;
  } user_regs_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_SEL      = 4'h3,
    ST_SEL_ACK  = 4'h4,
    ST_WDATA    = 4'h5,
    ST_WACK     = 4'h6,
    ST_RDATA    = 4'h7,
    ST_RACK     = 4'h8,
    ST_IGNORE   = 4'h9,
    ST_SEL_ACK_LAST = 4'hA
  } link_state_t;

endpackage

// *** thermometer_twowire_target.sv ***
// Two-wire target interface of the thermometer with strap-decoded address.

// Three-stage input synchroniser; the output follows once stages two and three agree.
module sync3
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_val_in,
  output logic      [WIDTH-1:0] stable_out
);

  logic [WIDTH-1:0] stage_1;
  logic [WIDTH-1:0] stage_2;
  logic [WIDTH-1:0] stage_3;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      stage_1 <= '0;
      stage_2 <= '0;
      stage_3 <= '0;
    end
    else
    begin
      stage_1 <= async_in;
      stage_2 <= stage_1;
      stage_3 <= stage_2;
    end
  end

  // During reset the output is zero; it then shows the idle value until all three stages hold pin samples.
  // Comparing the reset zeros left in the stages would fake a low pulse after reset.
  logic [1:0] fill;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      fill       <= 2'h0;
      stable_out <= '0;
    end
    else if (fill != 2'h3)
    begin
      fill       <= fill + 2'h1;
      stable_out <= reset_val_in;
    end
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (stage_2[i] == stage_3[i])
        begin
          stable_out[i] <= stage_3[i];
        end
      end
    end
  end

endmodule // sync3

module thermometer_twowire_target
  import thermo_twowire_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Two-wire link
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  // Address straps
  input  wire straps_t     straps_in,
  // Conversion engine side
  input  wire logic [15:0] temp_in,
  output user_regs_t       regs_out,
  output logic             soft_por_out
);

  logic        scl;
  logic        sda;
  straps_t     straps;
  logic        scl_d;
  logic        sda_d;
  link_state_t state;
  logic [3:0]  bit_cnt;
  logic [7:0]  rx_shift;
  logic [7:0]  tx_shift;
  logic        byte_idx;
  logic        reading;
  logic [1:0]  reg_select;
  logic [7:0]  write_hold;
  logic [6:0]  dev_addr;
  logic [6:0]  next_dev_addr;
  logic        ack_seen;
  logic [7:0]  hi_byte;
  logic [7:0]  lo_byte;

  sync3 #(.WIDTH(2)) u_sync_link
  (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .async_in     ({scl_in, sda_in}),
    .reset_val_in (2'h3),
    .stable_out   ({scl, sda})
  );

  sync3 #(.WIDTH(6)) u_sync_strap
  (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .async_in     (straps_in),
    .reset_val_in (6'h00),
    .stable_out   (straps)
  );

  wire scl_rise = scl && !scl_d;
  wire scl_fall = !scl && scl_d;
  wire start_ev = scl && scl_d && sda_d && !sda;
  wire stop_ev  = scl && scl_d && !sda_d && sda;
  wire byte_end = scl_fall && (bit_cnt == BITS_PER_BYTE);

  // Strap lookup, ordered strap 2, strap 1, strap 0.
  always_comb
  begin
    next_dev_addr = ADDR_RESET;
    case ({straps.strap_2, straps.strap_1, straps.strap_0})
      {STRAP_LOW,   STRAP_LOW,   STRAP_LOW  }: next_dev_addr = 7'h48;
      {STRAP_LOW,   STRAP_LOW,   STRAP_HIGH }: next_dev_addr = 7'h49;
      {STRAP_LOW,   STRAP_HIGH,  STRAP_LOW  }: next_dev_addr = 7'h4A;
      {STRAP_LOW,   STRAP_HIGH,  STRAP_HIGH }: next_dev_addr = 7'h4B;
      {STRAP_LOW,   STRAP_LOW,   STRAP_FLOAT}: next_dev_addr = 7'h2C;
      {STRAP_LOW,   STRAP_FLOAT, STRAP_LOW  }: next_dev_addr = 7'h28;
      {STRAP_LOW,   STRAP_HIGH,  STRAP_FLOAT}: next_dev_addr = 7'h2D;
      {STRAP_LOW,   STRAP_FLOAT, STRAP_HIGH }: next_dev_addr = 7'h29;
      {STRAP_LOW,   STRAP_FLOAT, STRAP_FLOAT}: next_dev_addr = 7'h35;
      {STRAP_HIGH,  STRAP_LOW,   STRAP_LOW  }: next_dev_addr = 7'h4C;
      {STRAP_HIGH,  STRAP_LOW,   STRAP_HIGH }: next_dev_addr = 7'h4D;
      {STRAP_HIGH,  STRAP_HIGH,  STRAP_LOW  }: next_dev_addr = 7'h4E;
      {STRAP_HIGH,  STRAP_HIGH,  STRAP_HIGH }: next_dev_addr = 7'h4F;
      {STRAP_HIGH,  STRAP_LOW,   STRAP_FLOAT}: next_dev_addr = 7'h2E;
      {STRAP_HIGH,  STRAP_FLOAT, STRAP_LOW  }: next_dev_addr = 7'h2A;
      {STRAP_HIGH,  STRAP_HIGH,  STRAP_FLOAT}: next_dev_addr = 7'h2F;
      {STRAP_HIGH,  STRAP_FLOAT, STRAP_HIGH }: next_dev_addr = 7'h2B;
      {STRAP_HIGH,  STRAP_FLOAT, STRAP_FLOAT}: next_dev_addr = 7'h36;
      {STRAP_FLOAT, STRAP_LOW,   STRAP_LOW  }: next_dev_addr = 7'h70;
      {STRAP_FLOAT, STRAP_LOW,   STRAP_HIGH }: next_dev_addr = 7'h72;
      {STRAP_FLOAT, STRAP_HIGH,  STRAP_LOW  }: next_dev_addr = 7'h73;
      {STRAP_FLOAT, STRAP_HIGH,  STRAP_HIGH }: next_dev_addr = 7'h75;
      {STRAP_FLOAT, STRAP_LOW,   STRAP_FLOAT}: next_dev_addr = 7'h71;
      {STRAP_FLOAT, STRAP_FLOAT, STRAP_LOW  }: next_dev_addr = 7'h76;
      {STRAP_FLOAT, STRAP_HIGH,  STRAP_FLOAT}: next_dev_addr = 7'h74;
      {STRAP_FLOAT, STRAP_FLOAT, STRAP_HIGH }: next_dev_addr = 7'h77;
      {STRAP_FLOAT, STRAP_FLOAT, STRAP_FLOAT}: next_dev_addr = 7'h37;
      default:                                 next_dev_addr = ADDR_RESET;
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      dev_addr <= ADDR_RESET;
      sda_out  <= 1'b0;
    end
    else
    begin
      scl_d    <= scl;
      sda_d    <= sda;
      dev_addr <= next_dev_addr;
      sda_out  <= 1'b0;
    end
  end

  // Upper byte of the selected register for the first read byte, lower byte for the second.
  function automatic logic [7:0] read_byte(input logic [1:0] sel, input logic low,
                                           input logic [15:0] temp, input user_regs_t r);
    logic [15:0] word;
    word = temp;
    case (sel)
      SEL_TEMP:  word = temp;
      SEL_CFG:   word = {r.cfg, r.cfg};
      SEL_THYST: word = r.thyst;
      SEL_TOS:   word = r.tos;
      default:   word = temp;
    endcase
    return low ? word[7:0] : word[15:8];
  endfunction

  assign hi_byte = read_byte(reg_select, 1'b0, temp_in, regs_out);
  assign lo_byte = read_byte(reg_select, 1'b1, temp_in, regs_out);

  // Link state machine; all data-line changes happen on falling clock edges.
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state        <= ST_IDLE;
      bit_cnt      <= 4'h0;
      rx_shift     <= 8'h00;
      tx_shift     <= 8'h00;
      byte_idx     <= 1'b0;
      reading      <= 1'b0;
      ack_seen     <= 1'b0;
      write_hold   <= 8'h00;
      sda_oe_out   <= 1'b0;
      soft_por_out <= 1'b0;
      reg_select   <= SEL_RESET;
      regs_out     <= '{cfg: CFG_RESET, thyst: THYST_RESET, tos: TOS_RESET};
    end
    else
    begin
      soft_por_out <= 1'b0;
      if (start_ev)
      begin
        // A repeated start keeps the selection for the following read.
        state      <= ST_ADDR;
        bit_cnt    <= 4'h0;
        sda_oe_out <= 1'b0;
      end
      else if (stop_ev)
      begin
        state      <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end
      else
      begin
        if (scl_rise && (state == ST_ADDR || state == ST_SEL || state == ST_WDATA))
        begin
          rx_shift <= {rx_shift[6:0], sda};
          bit_cnt  <= bit_cnt + 4'h1;
        end
        case (state)
          ST_IDLE, ST_IGNORE:
          begin
            sda_oe_out <= 1'b0;
          end
          ST_ADDR:
          begin
            if (byte_end)
            begin
              if (rx_shift[7:1] == dev_addr)
              begin
                reading    <= rx_shift[0];
                sda_oe_out <= 1'b1;
                state      <= ST_ADDR_ACK;
              end
              else
              begin
                state <= ST_IGNORE;
              end
            end
          end
          ST_ADDR_ACK:
          begin
            if (scl_fall)
            begin
              bit_cnt  <= 4'h0;
              byte_idx <= 1'b0;
              if (reading)
              begin
                // First data bit goes out right after the address acknowledge.
                tx_shift   <= {hi_byte[6:0], 1'b0};
                sda_oe_out <= !hi_byte[7];
                bit_cnt    <= 4'h1;
                state      <= ST_RDATA;
              end
              else
              begin
                sda_oe_out <= 1'b0;
                state      <= ST_SEL;
              end
            end
          end
          ST_SEL:
          begin
            if (byte_end)
            begin
              if (rx_shift == SOFT_POR_CODE)
              begin
                // Power-cycle equivalent; the byte is left unacknowledged.
                reg_select   <= SEL_RESET;
                regs_out     <= '{cfg: CFG_RESET, thyst: THYST_RESET, tos: TOS_RESET};
                soft_por_out <= 1'b1;
                state        <= ST_IGNORE;
              end
              else if (rx_shift[7:2] == SEL_UPPER_ZERO)
              begin
                reg_select <= rx_shift[1:0];
                sda_oe_out <= 1'b1;
                state      <= ST_SEL_ACK;
              end
              else
              begin
                state <= ST_IGNORE;
              end
            end
          end
          ST_SEL_ACK, ST_WACK:
          begin
            if (scl_fall)
            begin
              sda_oe_out <= 1'b0;
              bit_cnt    <= 4'h0;
              state      <= ST_WDATA;
            end
          end
          ST_WDATA:
          begin
            if (byte_end)
            begin
              // Bytes beyond what the selected register takes are left unacknowledged.
              state <= ST_IGNORE;
              if (reg_select == SEL_CFG && !byte_idx)
              begin
                regs_out.cfg <= rx_shift;
                sda_oe_out   <= 1'b1;
                byte_idx     <= 1'b1;
                state        <= ST_SEL_ACK_LAST;
              end
              else if ((reg_select == SEL_THYST || reg_select == SEL_TOS) && !byte_idx)
              begin
                write_hold <= rx_shift;
                sda_oe_out <= 1'b1;
                byte_idx   <= 1'b1;
                state      <= ST_WACK;
              end
              else if (reg_select == SEL_THYST && byte_idx)
              begin
                regs_out.thyst <= {write_hold, rx_shift};
                sda_oe_out     <= 1'b1;
                state          <= ST_SEL_ACK_LAST;
              end
              else if (reg_select == SEL_TOS && byte_idx)
              begin
                regs_out.tos <= {write_hold, rx_shift};
                sda_oe_out   <= 1'b1;
                state        <= ST_SEL_ACK_LAST;
              end
            end
          end
          ST_SEL_ACK_LAST:
          begin
            // Last data byte acknowledged; anything after it is refused.
            if (scl_fall)
            begin
              sda_oe_out <= 1'b0;
              state      <= ST_IGNORE;
            end
          end
          ST_RDATA:
          begin
            if (scl_fall)
            begin
              if (bit_cnt == BITS_PER_BYTE)
              begin
                sda_oe_out <= 1'b0;
                state      <= ST_RACK;
              end
              else
              begin
                sda_oe_out <= !tx_shift[7];
                tx_shift   <= {tx_shift[6:0], 1'b0};
                bit_cnt    <= bit_cnt + 4'h1;
              end
            end
          end
          ST_RACK:
          begin
            if (scl_rise)
            begin
              ack_seen <= !sda;
            end
            if (scl_fall)
            begin
              if (ack_seen && !byte_idx && reg_select != SEL_CFG)
              begin
                byte_idx   <= 1'b1;
                tx_shift   <= {lo_byte[6:0], 1'b0};
                sda_oe_out <= !lo_byte[7];
                bit_cnt    <= 4'h1;
                state      <= ST_RDATA;
              end
              else
              begin
                state <= ST_IGNORE;
              end
            end
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // thermometer_twowire_target

// *** thermometer_twowire_target_props.sv ***
// Concurrent checks on the two-wire target ports.
module thermometer_twowire_target_props
  import thermo_twowire_pkg::*;
(
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  // Link and register outputs
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire user_regs_t regs_out,
  input wire logic       soft_por_out
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  property p_drive_low;
    sda_oe_out |-> !sda_out;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("data pin driven high");

  property p_oe_edge;
    $changed(sda_oe_out) |-> !$past(scl_in);
  endproperty
  a_oe_edge: assert property (p_oe_edge)
    else $error("data drive changed while clock high");

  property p_hold;
    $rose(sda_oe_out) |-> sda_oe_out [*6];
  endproperty
  a_hold: assert property (p_hold)
    else $error("driven bit too short");

  property p_por_pulse;
    $rose(soft_por_out) |=> !soft_por_out;
  endproperty
  a_por_pulse: assert property (p_por_pulse)
    else $error("soft reset pulse too long");

  property p_por_clear;
    soft_por_out |-> ##[0:2] (regs_out == '0);
  endproperty
  a_por_clear: assert property (p_por_clear)
    else $error("soft reset left registers set");

  property p_regs_when;
    $changed(regs_out) |-> !$past(scl_in);
  endproperty
  a_regs_when: assert property (p_regs_when)
    else $error("registers changed while clock high");

  property p_idle_stop;
    (scl_in && $rose(sda_in)) |-> !sda_oe_out [*8];
  endproperty
  a_idle_stop: assert property (p_idle_stop)
    else $error("data driven after stop");

  property p_rst_vals;
    $fell(sys_rst_in) |-> !sda_oe_out && !soft_por_out && regs_out == '0;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("wrong values after reset");

  c_por: cover property ($rose(soft_por_out));
  c_regs: cover property ($changed(regs_out));
  c_drive: cover property ($rose(sda_oe_out));
endmodule // thermometer_twowire_target_props

bind thermometer_twowire_target thermometer_twowire_target_props props_u
(
  .clk_in       (clk_in),
  .sys_rst_in   (sys_rst_in),
  .scl_in       (scl_in),
  .sda_in       (sda_in),
  .sda_out      (sda_out),
  .sda_oe_out   (sda_oe_out),
  .regs_out     (regs_out),
  .soft_por_out (soft_por_out)
);

// *** thermometer_twowire_target_test.sv ***
// Self-checking bench for the thermometer two-wire target.
module thermometer_twowire_target_test
  import thermo_twowire_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        scl;
  logic        drv;
  logic        sda_out;
  logic        sda_oe_out;
  logic        soft_por_out;
  straps_t     straps = '0;
  logic [15:0] temp = 16'h0000;
  user_regs_t  regs;
  wire         sda = drv & ~(sda_oe_out & ~sda_out);
  int          failures = 0;
  int          n_compared = 0;
  int          por_seen = 0;
  logic [7:0]  q;
  logic        k;
  logic [15:0] v;
  localparam logic [5:0] ST [5] = '{6'h00, 6'h02, 6'h2A, 6'h19, 6'h24};
  localparam logic [6:0] AD [5] = '{7'h48, 7'h2C, 7'h37, 7'h2B, 7'h73};

  always #4 clk_in = ~clk_in;

  always @(posedge clk_in)
    if (soft_por_out === 1'b1)
      por_seen <= por_seen + 1;

  thermometer_twowire_target dut_u
  (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .scl_in       (scl),
    .sda_in       (sda),
    .sda_out      (sda_out),
    .sda_oe_out   (sda_oe_out),
    .straps_in    (straps),
    .temp_in      (temp),
    .regs_out     (regs),
    .soft_por_out (soft_por_out)
  );

  twowire_ctrl_model m_u
  (
    .clk_in      (clk_in),
    .sda_in      (sda),
    .scl_out     (scl),
    .sda_drv_out (drv)
  );

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic sel(input logic [7:0] s);
    m_u.start_c();
    m_u.xfer(8'h90, 1'b1, q, k);
    check(40'(k), 40'h0);
    m_u.xfer(s, 1'b1, q, k);
    check(40'(k), 40'h0);
  endtask

  task automatic wr(input logic [7:0] s, input logic [15:0] d, input int n);
    sel(s);
    for (int i = 0; i < n; i++)
    begin
      m_u.xfer(d[8*(n-1-i) +: 8], 1'b1, q, k);
      check(40'(k), 40'h0);
    end
    m_u.stop_c();
  endtask

  // A read always opens with its own start, so after sel it is a repeated start.
  task automatic rd(input int n, output logic [15:0] r);
    m_u.start_c();
    m_u.xfer(8'h91, 1'b1, q, k);
    check(40'(k), 40'h0);
    m_u.xfer(8'hFF, n == 1, q, k);
    r = {q, 8'h00};
    if (n == 2)
    begin
      m_u.xfer(8'hFF, 1'b1, q, k);
      r[7:0] = q;
    end
    check(40'(k), 40'h1);
    m_u.stop_c();
  endtask

  task automatic t_default_read();
    @(posedge clk_in);
    temp <= 16'hA5C3;
    rd(2, v);
    check(40'(v), 40'hA5C3);
    $display("default read done");
  endtask

  task automatic t_writes();
    wr(8'h01, 16'h00A5, 1);
    wr(8'h02, 16'h5678, 2);
    wr(8'h03, 16'h1234, 2);
    check(40'(regs), {8'hA5, 16'h5678, 16'h1234});
    $display("writes done");
  endtask

  task automatic t_reads();
    sel(8'h01);
    rd(1, v);
    check(40'(v), 40'hA500);
    rd(1, v);
    check(40'(v), 40'hA500);
    sel(8'h03);
    rd(2, v);
    check(40'(v), 40'h1234);
    rd(1, v);
    check(40'(v), 40'h1200);
    sel(8'h02);
    rd(2, v);
    check(40'(v), 40'h5678);
    sel(8'h00);
    rd(2, v);
    check(40'(v), 40'hA5C3);
    $display("reads done");
  endtask

  task automatic t_refuse();
    m_u.start_c();
    m_u.xfer(8'h92, 1'b1, q, k);
    check(40'(k), 40'h1);
    m_u.xfer(8'h01, 1'b1, q, k);
    check(40'(k), 40'h1);
    m_u.stop_c();
    sel(8'h01);
    m_u.stop_c();
    m_u.start_c();
    m_u.xfer(8'h90, 1'b1, q, k);
    m_u.xfer(8'h81, 1'b1, q, k);
    check(40'(k), 40'h1);
    m_u.stop_c();
    sel(8'h02);
    m_u.xfer(8'h11, 1'b1, q, k);
    m_u.xfer(8'h22, 1'b1, q, k);
    m_u.xfer(8'h33, 1'b1, q, k);
    check(40'(k), 40'h1);
    m_u.stop_c();
    check(40'(regs.thyst), 40'h1122);
    sel(8'h00);
    m_u.xfer(8'h44, 1'b1, q, k);
    check(40'(k), 40'h1);
    m_u.stop_c();
    $display("refusals done");
  endtask

  task automatic t_por();
    m_u.start_c();
    m_u.xfer(8'h90, 1'b1, q, k);
    m_u.xfer(SOFT_POR_CODE, 1'b1, q, k);
    check(40'(k), 40'h1);
    m_u.stop_c();
    check(40'(por_seen), 40'h1);
    check(40'(regs), 40'h0);
    rd(2, v);
    check(40'(v), 40'hA5C3);
    $display("soft reset done");
  endtask

  task automatic t_straps();
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_in);
      straps <= ST[i];
      repeat (8) @(posedge clk_in);
      m_u.start_c();
      m_u.xfer({AD[i], 1'b0}, 1'b1, q, k);
      check(40'(k), 40'h0);
      m_u.stop_c();
    end
    @(posedge clk_in);
    straps <= '0;
    $display("straps done");
  endtask

  initial
  begin
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    t_default_read();
    t_writes();
    t_reads();
    t_refuse();
    t_por();
    t_straps();
    wrap_up();
  end

  initial
  begin
    repeat (100000) @(posedge clk_in);
    failures++;
    wrap_up();
  end
endmodule // thermometer_twowire_target_test

// *** twowire_ctrl_model.sv ***
// Behavioural two-wire bus controller for the target's link.
module twowire_ctrl_model
(
  // Clock
  input  wire logic clk_in,
  // Wired data line level
  input  wire logic sda_in,
  // Controller drives; data high means released
  output logic      scl_out,
  output logic      sda_drv_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end

  // One 8-cycle bit: data moves while clock is low, sampled at end of high.
  task automatic bit_x(input logic b, output logic r);
    @(posedge clk_in);
    sda_drv_out <= b;
    repeat (5) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    r = sda_in;
    scl_out <= 1'b0;
  endtask

  // The wait lets the target release its acknowledge before the clock rises.
  task automatic start_c();
    @(posedge clk_in);
    sda_drv_out <= 1'b1;
    repeat (7) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    sda_drv_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    scl_out <= 1'b0;
  endtask

  task automatic stop_c();
    @(posedge clk_in);
    sda_drv_out <= 1'b0;
    repeat (7) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    sda_drv_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask

  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic k);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(a, k);
  endtask
endmodule // twowire_ctrl_model
